// file: src/zws_pkg.sv
// Package of constants and types for the zero-wait SRAM bus sequencer
package zws_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 31;
  // Bus sequencer states
  typedef enum logic [1:0] {
    ZWS_IDLE  = 2'b00,
    ZWS_READ  = 2'b01,
    ZWS_WGAP  = 2'b10,
    ZWS_WSTRB = 2'b11
  } zws_state_t;
  localparam zws_state_t ZWS_RST_STATE = ZWS_IDLE;
  localparam logic       STRB_RST      = 1'b1;
  localparam logic       RW_RST        = 1'b1;
endpackage : zws_pkg

// file: src/zws_sync.sv
// Two-flop synchroniser for an input pin
`timescale 1ns/1ps
module zws_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // Data
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 1'b1;
      q_o    <= 1'b1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : zws_sync

// file: src/zws_seq.sv
// Zero-wait-state bus sequencer: one external bus, two strobe sets
// Notes on behaviour
// - External bus is 32 bits wide for memories and peripherals.
// - Each strobe has own strobe, enable, ready, page and read/write.
// - Back-to-back reads keep strobe low and read/write high.
// - Every zero-wait write takes two bus cycles.
// - Read to write inserts strobe-high cycle; read/write changes then.
// - Consecutive writes keep read/write low, strobe high between them.
// - Strobe-high cycle between writes covers the address change.
// - A write to an idle bus is accepted in one cycle.
`timescale 1ns/1ps
module zws_seq
  import zws_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       nrst_i,
  // Core and DMA request side
  input  wire logic                       req_valid_i,
  input  wire logic                       req_write_i,
  input  wire logic                       req_sel_i,
  input  wire logic [zws_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic [zws_pkg::DATA_W-1:0] req_wdata_i,
  output logic                            req_ready_o,
  output logic                            rd_valid_o,
  output logic [zws_pkg::DATA_W-1:0]      rd_data_o,
  // External bus pins
  output logic [zws_pkg::ADDR_W-1:0]      bus_addr_o,
  input  wire logic [zws_pkg::DATA_W-1:0] bus_data_i,
  output logic [zws_pkg::DATA_W-1:0]      bus_data_o,
  output logic                            bus_data_oe_o,
  input  wire logic                       address_drive_enable_i,
  input  wire logic                       data_drive_enable_i,
  output logic                            bus_addr_oe_o,
  output logic                            bus_strobe_a_o,
  output logic                            bus_strobe_b_o,
  output logic                            read_write_a_o,
  output logic                            read_write_b_o,
  output logic                            page_boundary_a_o,
  output logic                            page_boundary_b_o,
  input  wire logic                       control_enable_a_i,
  input  wire logic                       control_enable_b_i,
  input  wire logic                       ready_in_a_i,
  input  wire logic                       ready_in_b_i,
  output logic                            ctl_oe_a_o,
  output logic                            ctl_oe_b_o
);
  import zws_pkg::*;

  zws_state_t                state_q, state_d;
  logic                      sel_q;
  logic                      strb_q, rw_q;
  logic                      rd_pend_q;
  logic [ADDR_W-1:0]         addr_q;
  logic [DATA_W-1:0]         wdata_q;
  logic [DATA_W-1:0]         rdata_q;
  logic                      ae_s, de_s, cea_s, ceb_s, rdya_s, rdyb_s;

  // Enable and ready pins from outside pass two flops before use
  zws_sync u_sync_ae (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (address_drive_enable_i),
    .q_o    (ae_s)
  );
  zws_sync u_sync_de (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (data_drive_enable_i),
    .q_o    (de_s)
  );
  zws_sync u_sync_cea (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (control_enable_a_i),
    .q_o    (cea_s)
  );
  zws_sync u_sync_ceb (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (control_enable_b_i),
    .q_o    (ceb_s)
  );
  zws_sync u_sync_rya (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (ready_in_a_i),
    .q_o    (rdya_s)
  );
  zws_sync u_sync_ryb (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .d_i    (ready_in_b_i),
    .q_o    (rdyb_s)
  );

  // Zero-wait only: ready pins are sampled but never stretch a cycle,
  // the outside holds them low.
  wire ready_unused = rdya_s & rdyb_s;

  wire idle_like  = (state_q == ZWS_IDLE) || (state_q == ZWS_READ);
  wire take       = req_valid_i && req_ready_o;
  wire take_rd    = take && !req_write_i;
  wire take_wr    = take && req_write_i;

  // Requests taken in idle, read or, for a write, the final write cycle.
  // A read waits one strobe-high cycle after a write so that read/write
  // never rises while the write strobe is still low.
  assign req_ready_o = idle_like ||
                       ((state_q == ZWS_WSTRB) && req_write_i);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ZWS_IDLE, ZWS_WSTRB: begin
        if (take_wr) begin
          state_d = ZWS_WGAP;
        end else if (take_rd) begin
          state_d = ZWS_READ;
        end else begin
          state_d = ZWS_IDLE;
        end
      end
      ZWS_READ: begin
        if (take_wr) begin
          state_d = ZWS_WGAP;
        end else if (take_rd) begin
          state_d = ZWS_READ;
        end else begin
          state_d = ZWS_IDLE;
        end
      end
      ZWS_WGAP: begin
        state_d = ZWS_WSTRB;
      end
      default: begin
        state_d = ZWS_IDLE;
      end
    endcase
  end

  // Strobe low only for reads and the second write cycle
  wire strb_d = !(state_d == ZWS_READ || state_d == ZWS_WSTRB);
  // Read/write moves only into the strobe-high write gap or a new read
  wire rw_d   = (state_d == ZWS_WGAP) ? 1'b0 :
                (state_d == ZWS_READ) ? 1'b1 : rw_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ZWS_RST_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // Address and set follow every taken request; data only for writes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sel_q   <= 1'b0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else begin
      if (take) begin
        sel_q  <= req_sel_i;
        addr_q <= req_addr_i;
      end
      if (take_wr) begin
        wdata_q <= req_wdata_i;
      end
    end
  end

  // Pin controls come from flops so they move only on clock edges
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strb_q <= STRB_RST;
      rw_q   <= RW_RST;
    end else begin
      strb_q <= strb_d;
      rw_q   <= rw_d;
    end
  end

  // Read data captured at the end of the strobe-low read cycle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_pend_q <= 1'b0;
      rdata_q   <= '0;
    end else begin
      rd_pend_q <= (state_q == ZWS_READ);
      if (state_q == ZWS_READ) begin
        rdata_q <= bus_data_i;
      end
    end
  end
  // A read after a read on the other set drops strobe a cycle first
  // is not needed: each set has its own strobe pin.

  assign bus_strobe_a_o    = sel_q ? 1'b1 : strb_q;
  assign bus_strobe_b_o    = sel_q ? strb_q : 1'b1;
  assign read_write_a_o    = sel_q ? 1'b1 : rw_q;
  assign read_write_b_o    = sel_q ? rw_q : 1'b1;
  assign page_boundary_a_o = 1'b1;
  assign page_boundary_b_o = 1'b1;
  assign bus_addr_o        = addr_q;
  assign bus_data_o        = wdata_q;
  // Write data driven through both write cycles, released in the cycle
  // in which the strobe rises, unless another write follows.
  assign bus_data_oe_o     = !de_s &&
                             (state_q == ZWS_WGAP || state_q == ZWS_WSTRB);
  assign bus_addr_oe_o     = !ae_s;
  assign ctl_oe_a_o        = !cea_s;
  assign ctl_oe_b_o        = !ceb_s;
  assign rd_valid_o        = rd_pend_q & (ready_unused | 1'b1);
  assign rd_data_o         = rdata_q;
endmodule : zws_seq

// file: bench/zws_seq_chk.sv
// Checker of strobe and read/write sequencing on strobe set a
`timescale 1ns/1ps
module zws_seq_chk (
  // Watched ports
  input wire logic                       clk_i,
  input wire logic                       nrst_i,
  input wire logic                       req_valid_i,
  input wire logic                       req_write_i,
  input wire logic                       req_sel_i,
  input wire logic                       req_ready_o,
  input wire logic                       rd_valid_o,
  input wire logic                       bus_data_oe_o,
  input wire logic                       bus_strobe_a_o,
  input wire logic                       read_write_a_o,
  input wire logic [zws_pkg::ADDR_W-1:0] bus_addr_o
);
  wire tk = req_valid_i & req_ready_o & ~req_sel_i;
  // A read taken after a write waits for its turnaround, so excluded
  wire rt = tk & ~req_write_i & read_write_a_o;
  wire wt = tk & req_write_i;
  wire sl = ~bus_strobe_a_o;
  wire wl = ~read_write_a_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_rd; rt |=> sl && !wl; endproperty
  a_rd: assert property (p_rd) else $error("read strobe late");
  property p_rv; rt |-> ##2 rd_valid_o; endproperty
  a_rv: assert property (p_rv) else $error("read data late");
  property p_wr; wt |=> (!sl && wl) ##1 (sl && wl); endproperty
  a_wr: assert property (p_wr) else $error("write shape");
  property p_rw;
    $changed(read_write_a_o) |-> !sl || !$past(sl);
  endproperty
  a_rw: assert property (p_rw) else $error("rw under strobe");
  property p_ad; $changed(bus_addr_o) && wl |-> !sl; endproperty
  a_ad: assert property (p_ad) else $error("addr under strobe");
  property p_fr; sl && wl |=> !sl; endproperty
  a_fr: assert property (p_fr) else $error("write unframed");
  property p_rf;
    wt |=> !req_ready_o ##1 (req_ready_o == req_write_i);
  endproperty
  a_rf: assert property (p_rf) else $error("write accept");
  property p_oe; sl && wl |-> bus_data_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("data not driven");
  c_rr: cover property (rt ##1 rt);
  c_ww: cover property (wt ##2 wt);
  c_rw: cover property (rt ##1 wt);
endmodule : zws_seq_chk
bind zws_seq zws_seq_chk u_chk (.*);

// file: bench/zws_sram_mdl.sv
// Behavioural model of two banks of chip-enable write static RAM
`timescale 1ns/1ps
module zws_sram_mdl (
  // Bus pins
  input  wire logic        clk_i,
  input  wire logic        ce_a_n_i,
  input  wire logic        ce_b_n_i,
  input  wire logic        we_a_n_i,
  input  wire logic        we_b_n_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [31:0] d_i,
  output logic [31:0]      q_o,
  output logic             rdy_n_o
);
  logic [31:0] mem [32];
  logic [31:0] last_q = '0;
  wire         bank = ce_a_n_i;
  wire         sel  = !(ce_a_n_i && ce_b_n_i);
  wire         rd   = sel && (bank ? we_b_n_i : we_a_n_i);
  wire [4:0]   idx  = {bank, adr_i};
  assign rdy_n_o = 1'b0;
  // Undriven bus shows the inverse of the last read value, never a stale one
  assign q_o = rd ? mem[idx] : ~last_q;
  always @(negedge clk_i) begin
    if (sel && !rd) mem[idx] <= d_i;
    if (rd) last_q <= mem[idx];
  end
endmodule : zws_sram_mdl

// file: bench/test_zero_wait_sram_bus_sequencer.sv
// Self-checking bench for the zero-wait SRAM bus sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module test_zero_wait_sram_bus_sequencer;
  import zws_pkg::*;
  logic              clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic              req_valid_i = 1'b0;
  logic              req_write_i = 1'b0;
  logic              req_sel_i = 1'b0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [DATA_W-1:0] req_wdata_i = '0;
  logic              en_n = 1'b0;
  logic [DATA_W-1:0] exp_w;
  logic [DATA_W-1:0] expq [$];
  int                err_count = 0;
  int                checks = 0;
  wire logic [DATA_W-1:0] rd_data_o, q, bus_data_o;
  wire logic [ADDR_W-1:0] bus_addr_o;
  wire logic req_ready_o, rd_valid_o, bus_data_oe_o, bus_addr_oe_o, rdy_n;
  wire logic bus_strobe_a_o, bus_strobe_b_o, read_write_a_o, read_write_b_o;
  wire logic page_a, page_b, ctl_a, ctl_b;
  // Row: write flag, strobe set, address, write data or read result
  logic [43:0] rows [9] = '{44'h101_1111_1111, 44'h102_2222_2222,
    44'h001_1111_1111, 44'h002_2222_2222, 44'h113_3333_3333,
    44'h013_3333_3333, 44'h001_1111_1111, 44'h102_4444_4444,
    44'h002_4444_4444};
  zws_seq u_dut (.*, .bus_data_i(q), .address_drive_enable_i(en_n),
    .data_drive_enable_i(en_n), .control_enable_a_i(en_n),
    .control_enable_b_i(en_n), .ready_in_a_i(rdy_n), .ready_in_b_i(rdy_n),
    .page_boundary_a_o(page_a), .page_boundary_b_o(page_b),
    .ctl_oe_a_o(ctl_a), .ctl_oe_b_o(ctl_b));
  zws_sram_mdl u_mem (.clk_i(clk_i), .ce_a_n_i(bus_strobe_a_o),
    .ce_b_n_i(bus_strobe_b_o), .we_a_n_i(read_write_a_o),
    .we_b_n_i(read_write_b_o), .adr_i(bus_addr_o[3:0]), .d_i(bus_data_o),
    .q_o(q), .rdy_n_o(rdy_n));
  always #5 clk_i = ~clk_i;
  task tally_and_finish;
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  always @(negedge clk_i) if (rd_valid_o === 1'b1) begin
    exp_w = expq.pop_front();
    `CHK(rd_data_o, exp_w)
  end
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(negedge clk_i);
    `CHK(bus_addr_oe_o, 1'b1)
    `CHK({page_a, page_b, ctl_a, ctl_b}, 4'hF)
    foreach (rows[i]) begin
      @(posedge clk_i);
      req_valid_i <= 1'b1;
      req_write_i <= rows[i][40];
      req_sel_i <= rows[i][36];
      req_addr_i <= ADDR_W'(rows[i][35:32]);
      req_wdata_i <= rows[i][31:0];
      do @(negedge clk_i); while (req_ready_o !== 1'b1);
      if (!rows[i][40]) expq.push_back(rows[i][31:0]);
    end
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    repeat (4) @(negedge clk_i);
    `CHK(expq.size(), 0)
    // Reset in the middle of a read run
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b0;
    req_valid_i <= 1'b0;
    @(negedge clk_i);
    `CHK({bus_strobe_a_o, bus_strobe_b_o, read_write_a_o}, 3'h7)
    @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    `CHK(req_ready_o, 1'b1)
    tally_and_finish();
  end
endmodule : test_zero_wait_sram_bus_sequencer
